//--- hdl/pcg_defines.svh
// Offsets, field positions and reset values of the clock gating block
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_OFF_RUN_GATE      12'h104
`define PCG_OFF_SLEEP_GATE    12'h114
`define PCG_OFF_DEEP_GATE     12'h124
`define PCG_OFF_CLOCK_CONFIG  12'h060
`define PCG_OFF_FAULT_STATUS  12'h200
`define PCG_ADDR_W            12
`define PCG_GATE_RESET        32'h00000000
`define PCG_CONFIG_RESET      32'h00000000
`define PCG_GATE_WMASK        32'h030f1101
`define PCG_AUTO_GATING_BIT   27
`define PCG_CONFIG_WMASK      32'h08000000
`define PCG_NUM_UNITS         10
`define PCG_BIT_SERIAL0       0
`define PCG_BIT_QUAD0         8
`define PCG_BIT_TWOWIRE0      12
`define PCG_BIT_GP_TIMER_ZERO_CLOCK_EN        16
`define PCG_BIT_GP_TIMER_ONE_CLOCK_EN        17
`define PCG_BIT_GP_TIMER_TWO_CLOCK_EN        18
`define PCG_BIT_GP_TIMER_THREE_CLOCK_EN        19
`define PCG_BIT_COMPARATOR_ZERO_CLOCK_EN         24
`define PCG_BIT_COMPARATOR_ONE_CLOCK_EN         25

`endif

//--- hdl/pcg_pkg.sv
// Types shared by the clock gating block
`default_nettype none
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP_SLEEP
  } pcg_mode_t;
  typedef logic [31:0] pcg_word_t;
  typedef logic [9:0]  pcg_units_t;
endpackage : pcg_pkg
`default_nettype wire

//--- hdl/pcg_gate_reg.sv
// One masked gating register with reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"
module pcg_gate_reg #(
  parameter logic [31:0] WMASK = `PCG_GATE_WMASK,
  parameter logic [31:0] RVAL  = `PCG_GATE_RESET
) (
  input  wire logic        mclk,    // System clock
  input  wire logic        rst,     // Sync reset, high
  input  wire logic        we,      // Write this register
  input  wire logic [31:0] wdata,   // Write data
  output logic      [31:0] q        // Stored value
);
  logic [31:0] q_reg;
  logic [31:0] q_next;

  always_comb begin
    q_next = q_reg;
    // Reserved positions are masked so they stay zero
    if (we) begin
      q_next = wdata & WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_reg <= RVAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : pcg_gate_reg
`default_nettype wire

//--- hdl/pcg_access_guard.sv
// Bus fault detection for accesses to unclocked peripheral units
`timescale 1ns/1ps
`default_nettype none
module pcg_access_guard (
  input  wire logic                 mclk,      // System clock
  input  wire logic                 rst,       // Sync reset, high
  input  wire logic [9:0]           unit_en,   // Live clock enables
  input  wire logic [9:0]           unit_sel,  // Unit addressed, one-hot
  input  wire logic                 unit_acc,  // Access strobe to a unit
  output logic                      fault,     // Fault pulse
  output logic                      done       // Normal completion pulse
);
  logic fault_reg;
  logic fault_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    fault_next = 1'b0;
    done_next  = 1'b0;
    if (unit_acc) begin
      if ((unit_sel & ~unit_en) != 10'h000) begin
        fault_next = 1'b1;
      end else begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      done_reg  <= done_next;
    end
  end

  assign fault = fault_reg;
  assign done  = done_reg;
endmodule : pcg_access_guard
`default_nettype wire

//--- hdl/pcg_top.sv
// Peripheral clock gating control: registers, mode select, fault check
// How it works
// R01 - Set bit delivers clock to unit
// R02 - Clear bit withholds clock, unit disabled
// R03 - Access to unclocked unit returns fault
// R04 - All gating bits reset to zero
// R05 - Separate run, sleep, deep-sleep registers
// R06 - Auto-gating bit enables sleep registers
// R07 - Bit 0 enables serial port zero
// R08 - Bit 8 enables quadrature decoder zero
// R09 - Bit 12 enables two-wire zero
// R10 - Bits 16,17 enable timers zero, one
// R11 - Reserved bits read zero, read-only
// R12 - Deep-sleep register at offset 0x124
// R13 - Bits 24,25 enable comparators zero, one
// R14 - Bits 18,19 enable timers two, three
// R15 - Power mode picks applied register
// R16 - Writes to reserved bits ignored
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic                 mclk,        // System clock, 10 MHz
  input  wire logic                 rst,         // Sync reset, high
  input  wire logic [11:0]          reg_addr,    // Register byte offset
  input  wire logic [31:0]          reg_wdata,   // Register write data
  input  wire logic                 reg_wr,      // Write strobe
  input  wire logic                 reg_rd,      // Read strobe
  output logic      [31:0]          reg_rdata,   // Read data, next cycle
  input  wire pcg_pkg::pcg_mode_t   power_mode,  // Current power mode
  input  wire logic [9:0]           unit_sel,    // Unit hit by bus access
  input  wire logic                 unit_acc,    // Bus access to a unit
  output logic                      unit_fault,  // Access faulted
  output logic                      unit_done,   // Access completed
  output logic                      serial_port_zero_clock_en,        // Clk
  output logic                      quadrature_decoder_zero_clock_en, // Clk
  output logic                      two_wire_zero_clock_en,           // Clk
  output logic                      gp_timer_zero_clock_en,           // Clk
  output logic                      gp_timer_one_clock_en,            // Clk
  output logic                      gp_timer_two_clock_en,            // Clk
  output logic                      gp_timer_three_clock_en,          // Clk
  output logic                      comparator_zero_clock_en,         // Clk
  output logic                      comparator_one_clock_en           // Clk
);
  import pcg_pkg::*;

  pcg_word_t  run_unit_clock_gate;
  pcg_word_t  sleep_unit_clock_gate;
  pcg_word_t  deep_sleep_unit_clock_gate;
  pcg_word_t  run_mode_clock_config;
  pcg_word_t  applied;
  pcg_word_t  en_reg;
  pcg_word_t  en_next;
  pcg_word_t  rdata_reg;
  pcg_word_t  rdata_next;
  logic [9:0] fault_cnt_reg;
  logic [9:0] fault_cnt_next;
  pcg_units_t unit_en;
  logic       auto_gating_select;
  logic       wr_run;
  logic       wr_sleep;
  logic       wr_deep;
  logic       wr_cfg;
  logic       clr_faults;

  // Address decode for writes
  always_comb begin
    wr_run     = 1'b0;
    wr_sleep   = 1'b0;
    wr_deep    = 1'b0;
    wr_cfg     = 1'b0;
    clr_faults = 1'b0;
    if (reg_wr && reg_addr == `PCG_OFF_RUN_GATE) begin
      wr_run = 1'b1;
    end else if (reg_wr && reg_addr == `PCG_OFF_SLEEP_GATE) begin
      wr_sleep = 1'b1;
    end else if (reg_wr && reg_addr == `PCG_OFF_DEEP_GATE) begin
      wr_deep = 1'b1; // see R12
    end else if (reg_wr && reg_addr == `PCG_OFF_CLOCK_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == `PCG_OFF_FAULT_STATUS) begin
      clr_faults = 1'b1;
    end
  end

  // Three independent gating registers; reserved bits masked off
  pcg_gate_reg u_run (  // see R05
    .mclk  (mclk),
    .rst   (rst),
    .we    (wr_run),
    .wdata (reg_wdata),
    .q     (run_unit_clock_gate)
  );
  pcg_gate_reg u_sleep (  // see R05
    .mclk  (mclk),
    .rst   (rst),
    .we    (wr_sleep),
    .wdata (reg_wdata),
    .q     (sleep_unit_clock_gate)
  );
  pcg_gate_reg u_deep (  // see R16
    .mclk  (mclk),
    .rst   (rst),
    .we    (wr_deep),
    .wdata (reg_wdata),
    .q     (deep_sleep_unit_clock_gate)
  );
  pcg_gate_reg #(
    .WMASK (`PCG_CONFIG_WMASK),
    .RVAL  (`PCG_CONFIG_RESET)
  ) u_cfg (
    .mclk  (mclk),
    .rst   (rst),
    .we    (wr_cfg),
    .wdata (reg_wdata),
    .q     (run_mode_clock_config)
  );

  assign auto_gating_select = run_mode_clock_config[`PCG_AUTO_GATING_BIT];

  // Without auto gating the run register stays in force in every mode
  always_comb begin
    applied = run_unit_clock_gate;
    case (power_mode)
      PCG_MODE_SLEEP: begin
        if (auto_gating_select) begin // see R06
          applied = sleep_unit_clock_gate; // see R15
        end
      end
      PCG_MODE_DEEP_SLEEP: begin
        if (auto_gating_select) begin // see R06
          applied = deep_sleep_unit_clock_gate; // see R15
        end
      end
      default: begin
        applied = run_unit_clock_gate;
      end
    endcase
  end

  // Registered enables keep the clock gates glitch free
  always_comb begin
    en_next = applied;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      en_reg <= `PCG_GATE_RESET; // see R04
    end else begin
      en_reg <= en_next; // see R01
    end
  end

  assign serial_port_zero_clock_en        = en_reg[`PCG_BIT_SERIAL0];  // see R07
  assign quadrature_decoder_zero_clock_en = en_reg[`PCG_BIT_QUAD0];    // see R08
  assign two_wire_zero_clock_en           = en_reg[`PCG_BIT_TWOWIRE0]; // see R09
  assign gp_timer_zero_clock_en           = en_reg[`PCG_BIT_GP_TIMER_ZERO_CLOCK_EN];   // see R10
  assign gp_timer_one_clock_en            = en_reg[`PCG_BIT_GP_TIMER_ONE_CLOCK_EN];   // see R10
  assign gp_timer_two_clock_en            = en_reg[`PCG_BIT_GP_TIMER_TWO_CLOCK_EN];   // see R14
  assign gp_timer_three_clock_en          = en_reg[`PCG_BIT_GP_TIMER_THREE_CLOCK_EN];   // see R14
  assign comparator_zero_clock_en         = en_reg[`PCG_BIT_COMPARATOR_ZERO_CLOCK_EN];    // see R13
  assign comparator_one_clock_en          = en_reg[`PCG_BIT_COMPARATOR_ONE_CLOCK_EN];    // see R13

  // Unit order in unit_sel/unit_en: serial, quad, two-wire, timers 0-3, comps
  assign unit_en = {1'b0, comparator_one_clock_en, comparator_zero_clock_en,
                    gp_timer_three_clock_en, gp_timer_two_clock_en,
                    gp_timer_one_clock_en, gp_timer_zero_clock_en,
                    two_wire_zero_clock_en, quadrature_decoder_zero_clock_en,
                    serial_port_zero_clock_en}; // see R02

  pcg_access_guard u_guard ( // see R03
    .mclk     (mclk),
    .rst      (rst),
    .unit_en  (unit_en),
    .unit_sel (unit_sel),
    .unit_acc (unit_acc),
    .fault    (unit_fault),
    .done     (unit_done)
  );

  // Sticky per-unit fault record; a new fault wins over a clear
  always_comb begin
    fault_cnt_next = fault_cnt_reg;
    if (clr_faults) begin
      fault_cnt_next = fault_cnt_reg & ~reg_wdata[9:0];
    end
    if (unit_acc) begin
      fault_cnt_next = fault_cnt_next | (unit_sel & ~unit_en);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_cnt_reg <= 10'h000;
    end else begin
      fault_cnt_reg <= fault_cnt_next;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_rd && reg_addr == `PCG_OFF_RUN_GATE) begin
      rdata_next = run_unit_clock_gate;
    end else if (reg_rd && reg_addr == `PCG_OFF_SLEEP_GATE) begin
      rdata_next = sleep_unit_clock_gate;
    end else if (reg_rd && reg_addr == `PCG_OFF_DEEP_GATE) begin
      rdata_next = deep_sleep_unit_clock_gate; // see R11
    end else if (reg_rd && reg_addr == `PCG_OFF_CLOCK_CONFIG) begin
      rdata_next = run_mode_clock_config;
    end else if (reg_rd && reg_addr == `PCG_OFF_FAULT_STATUS) begin
      rdata_next = {22'h000000, fault_cnt_reg};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  property p_reset_zero;
    @(posedge mclk) $past(rst) |-> en_reg == `PCG_GATE_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see R04
    else $error("enables not zero after reset");

  property p_reserved_zero; // see R11
    @(posedge mclk) disable iff (rst)
      (deep_sleep_unit_clock_gate & ~`PCG_GATE_WMASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see R11, R16
    else $error("reserved gating bit set");

  property p_deep_write; // see R12
    @(posedge mclk) disable iff (rst)
      (reg_wr && reg_addr == `PCG_OFF_DEEP_GATE) |=>
        deep_sleep_unit_clock_gate == ($past(reg_wdata) & `PCG_GATE_WMASK);
  endproperty
  a_deep_write: assert property (p_deep_write) // see R12
    else $error("deep sleep register write lost");

  property p_run_mode; // see R15
    @(posedge mclk) disable iff (rst)
      (power_mode == PCG_MODE_RUN) |=> en_reg == $past(run_unit_clock_gate);
  endproperty
  a_run_mode: assert property (p_run_mode) // see R15
    else $error("run register not applied");

  property p_deep_auto; // see R06
    @(posedge mclk) disable iff (rst)
      (power_mode == PCG_MODE_DEEP_SLEEP && auto_gating_select) |=>
        en_reg == $past(deep_sleep_unit_clock_gate);
  endproperty
  a_deep_auto: assert property (p_deep_auto) // see R06
    else $error("deep sleep register not applied");

  property p_no_auto; // see R06
    @(posedge mclk) disable iff (rst)
      !auto_gating_select |=> en_reg == $past(run_unit_clock_gate);
  endproperty
  a_no_auto: assert property (p_no_auto) // see R06
    else $error("sleep register used without auto gating");

  property p_fault; // see R03
    @(posedge mclk) disable iff (rst)
      (unit_acc && unit_sel == 10'h001 && !serial_port_zero_clock_en)
        |=> unit_fault && !unit_done;
  endproperty
  a_fault: assert property (p_fault) // see R03
    else $error("access to gated unit did not fault");

  property p_ok; // see R01
    @(posedge mclk) disable iff (rst)
      (unit_acc && unit_sel == 10'h004 && two_wire_zero_clock_en)
        |=> unit_done && !unit_fault;
  endproperty
  a_ok: assert property (p_ok) // see R01
    else $error("access to clocked unit faulted");

  // Sleep selection needs both the mode and the auto gating bit
  sequence s_sleep_auto;
    power_mode == PCG_MODE_SLEEP && auto_gating_select;
  endsequence

  property p_sleep_auto;
    @(posedge mclk) disable iff (rst)
      s_sleep_auto |=> en_reg == $past(sleep_unit_clock_gate);
  endproperty
  a_sleep_auto: assert property (p_sleep_auto) // see R06
    else $error("sleep register not applied");

  property p_gated_timer;
    @(posedge mclk) disable iff (rst)
      (unit_acc && unit_sel == 10'h040 && !gp_timer_three_clock_en)
        |=> unit_fault && !unit_done;
  endproperty
  a_gated_timer: assert property (p_gated_timer) // see R02
    else $error("access to unclocked timer completed");

  // Read data stands one cycle only, so an idle bus reads zero
  property p_rd_idle;
    @(posedge mclk) disable iff (rst)
      !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // see R12
    else $error("read data held past its cycle");
endmodule : pcg_top
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"
module tb;
  import pcg_pkg::*;
  logic             mclk;
  logic             rst;
  logic [11:0]      reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  pcg_mode_t        power_mode;
  logic [9:0]       unit_sel;
  logic             unit_acc;
  logic             unit_fault;
  logic             unit_done;
  wire logic [8:0]  en_vec;
  int               bad_count;
  int               n_tests;
  int               cycles = 0;
  int               pos [9] = '{0, 8, 12, 16, 17, 18, 19, 24, 25};

  pcg_top DUT (
    .mclk                             (mclk),
    .rst                              (rst),
    .reg_addr                         (reg_addr),
    .reg_wdata                        (reg_wdata),
    .reg_wr                           (reg_wr),
    .reg_rd                           (reg_rd),
    .reg_rdata                        (reg_rdata),
    .power_mode                       (power_mode),
    .unit_sel                         (unit_sel),
    .unit_acc                         (unit_acc),
    .unit_fault                       (unit_fault),
    .unit_done                        (unit_done),
    .serial_port_zero_clock_en        (en_vec[0]),
    .quadrature_decoder_zero_clock_en (en_vec[1]),
    .two_wire_zero_clock_en           (en_vec[2]),
    .gp_timer_zero_clock_en           (en_vec[3]),
    .gp_timer_one_clock_en            (en_vec[4]),
    .gp_timer_two_clock_en            (en_vec[5]),
    .gp_timer_three_clock_en          (en_vec[6]),
    .comparator_zero_clock_en         (en_vec[7]),
    .comparator_one_clock_en          (en_vec[8])
  );

  always #50 mclk = ~mclk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bits(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits

  function automatic logic [8:0] en_of(input logic [31:0] w);
    return {w[25], w[24], w[19], w[18], w[17], w[16], w[12], w[8], w[0]};
  endfunction : en_of

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk_word(reg_rdata, exp);
  endtask : rd_chk

  // Enables are registered, so allow the one-cycle lag before looking
  task automatic en_chk(input logic [8:0] exp);
    repeat (2) @(posedge mclk);
    #1 chk_bits({1'b0, en_vec}, {1'b0, exp});
  endtask : en_chk

  task automatic acc_chk(input int u, input logic clocked);
    @(posedge mclk);
    unit_acc <= 1'b1;
    unit_sel <= 10'h001 << u;
    @(posedge mclk);
    unit_acc <= 1'b0;
    unit_sel <= 10'h000;
    #1 chk_bits({8'h00, unit_fault, unit_done}, {8'h00, !clocked, clocked});
  endtask : acc_chk

  task automatic t_reset();
    rd_chk(`PCG_OFF_RUN_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_SLEEP_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_DEEP_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_CLOCK_CONFIG, 32'h00000000);
    en_chk(9'h000);
    acc_chk(0, 1'b0);
    rd_chk(`PCG_OFF_FAULT_STATUS, 32'h00000001);
    wr_reg(`PCG_OFF_FAULT_STATUS, 32'h00000001);
    rd_chk(`PCG_OFF_FAULT_STATUS, 32'h00000000);
  endtask : t_reset

  // Reserved positions must refuse ones and keep reading zero
  task automatic t_mask();
    wr_reg(`PCG_OFF_DEEP_GATE, 32'hffffffff);
    rd_chk(`PCG_OFF_DEEP_GATE, 32'h030f1101);
    @(posedge mclk);
    #1 chk_word(reg_rdata, 32'h00000000);
    wr_reg(`PCG_OFF_DEEP_GATE, 32'hfcf0eefe);
    rd_chk(`PCG_OFF_DEEP_GATE, 32'h00000000);
    wr_reg(12'h300, 32'h12345678);
    rd_chk(12'h300, 32'h00000000);
  endtask : t_mask

  // Walk one enable bit; each unit completes, its neighbour faults
  task automatic t_bits();
    logic [31:0] w;
    for (int i = 0; i < 9; i++) begin
      w = 32'h00000001 << pos[i];
      wr_reg(`PCG_OFF_RUN_GATE, w);
      rd_chk(`PCG_OFF_RUN_GATE, w);
      en_chk(en_of(w));
      acc_chk(i, 1'b1);
      acc_chk((i + 1) % 9, 1'b0);
    end
  endtask : t_bits

  task automatic t_modes();
    pcg_mode_t md [3] = '{PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP_SLEEP};
    logic [31:0] gw [3] = '{32'h00000001, 32'h00000100, 32'h00001000};
    wr_reg(`PCG_OFF_RUN_GATE, gw[0]);
    wr_reg(`PCG_OFF_SLEEP_GATE, gw[1]);
    wr_reg(`PCG_OFF_DEEP_GATE, gw[2]);
    wr_reg(`PCG_OFF_CLOCK_CONFIG, 32'hffffffff);
    rd_chk(`PCG_OFF_CLOCK_CONFIG, 32'h08000000);
    rd_chk(`PCG_OFF_SLEEP_GATE, gw[1]);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      power_mode <= md[k];
      en_chk(en_of(gw[k]));
      acc_chk(k, 1'b1);
      acc_chk((k + 1) % 3, 1'b0);
    end
    wr_reg(`PCG_OFF_CLOCK_CONFIG, 32'h00000000);
    for (int k = 2; k >= 0; k--) begin
      @(posedge mclk);
      power_mode <= md[k];
      en_chk(en_of(gw[0]));
    end
  endtask : t_modes

  // A reset in mid-run must clear registers, fault record and enables
  task automatic t_rerun();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(`PCG_OFF_RUN_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_SLEEP_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_DEEP_GATE, 32'h00000000);
    rd_chk(`PCG_OFF_CLOCK_CONFIG, 32'h00000000);
    rd_chk(`PCG_OFF_FAULT_STATUS, 32'h00000000);
    en_chk(9'h000);
  endtask : t_rerun

  initial begin
    mclk       = 1'b0;
    rst        = 1'b1;
    reg_addr   = 12'h000;
    reg_wdata  = 32'h00000000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    power_mode = PCG_MODE_RUN;
    unit_sel   = 10'h000;
    unit_acc   = 1'b0;
    bad_count  = 0;
    n_tests    = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_mask();
    t_bits();
    t_modes();
    t_rerun();
    results();
  end
endmodule : tb
`default_nettype wire
